// *** regbuf_pkg.sv ***
// Package of constants for the configurable registered buffer, plus the per-bit
// capture slice that the top level instantiates. Assumes a single link clock drives the slice.
package regbuf_pkg;

  // Channel counts
  localparam int WIDE_BITS   = 25;
  localparam int NARROW_BITS = 14;

  // Bit positions within the wide input vector (channel n sits at n-1)
  localparam int POS_1TO1_CKE = 0;
  localparam int POS_1TO1_ODT = 3;
  localparam int POS_CS       = 6;
  localparam int POS_B_ODT    = 10;
  localparam int POS_B_CKE    = 13;

  // Channels that always capture, per mapping
  localparam logic [WIDE_BITS-1:0] UNGATED_1TO1   = 25'h0000049;
  localparam logic [WIDE_BITS-1:0] UNGATED_BANK_A = 25'h0000049;
  localparam logic [WIDE_BITS-1:0] UNGATED_BANK_B = 25'h0002440;

  // Channels that carry data, per mapping; the rest are unused terminals
  localparam logic [WIDE_BITS-1:0] ACTIVE_WIDE   = 25'h1FFFFFF;
  localparam logic [WIDE_BITS-1:0] ACTIVE_NARROW = 25'h0003FFF;

  localparam logic [WIDE_BITS-1:0] ALL_ZERO_WIDE = 25'h0000000;
  localparam logic [1:0]           SYNC_RESET    = 2'h0;

  // Mode encoding is {fanout_select, bank_select}; bank is ignored in 1:1
  typedef enum logic [1:0] {
    MODE_1TO1   = 2'h0,
    MODE_1TO1_X = 2'h1,
    MODE_BANK_A = 2'h2,
    MODE_BANK_B = 2'h3
  } mode_t;

endpackage

`timescale 1ns/1ns

// Bank of capture flops; a bit loads on each edge unless its hold line is high
module capture_slice
  import regbuf_pkg::*;
#(
  parameter int W = WIDE_BITS
) (
  // Clock and reset
  input  wire logic         clk_link,
  input  wire logic         clear,
  // Data
  input  wire logic [W-1:0] d,
  input  wire logic [W-1:0] hold,
  output logic      [W-1:0] q
);

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk_link or posedge clear) begin
        if (clear) begin
          q[i] <= 1'b0;
        end else if (!hold[i]) begin
          q[i] <= d[i];
        end
      end
    end
  endgenerate

endmodule // capture_slice

// *** configurable_registered_buffer.sv ***
// Top level of the configurable registered buffer: 25-bit 1:1 or 14-bit 1:2 with
// two bank mappings. Assumes clk_link is the true-polarity side of the differential
// clock and that the negative side is its complement.
//
// Summary of operation
// - Data inputs are captured when the positive clock rises.
// - Active-low reset clears every link-side register and forces the registered outputs low, asynchronously.
// - During reset the data and chip-select receivers are disabled.
// - Both chip selects high on an edge: gated registers do not load.
// - Gated outputs hold while both chip selects are high, else update.
// - Clock-enable, termination and chip-select channels capture on every edge.
// - 1:1 gates channels 2,3,5,6,8-25; channels 1,4,7 ungated.
// - 1:2 bank A gates channels 2,3,5,6,8-14 and both copies.
// - 1:2 bank B gates 1-6,8-10,12,13; 7,11,14 ungated.
// - In 1:2 modes each captured input drives identical copies A and B.
// - Two static configuration inputs select 1:1, bank A or bank B.
// - Unused terminals: inputs ignored, outputs driven low.
// - Fanout select low is 1:1, high is 1:2; bank select low A.
// - Reset overrides chip-select gating and forces outputs low.
// - Either chip select low: gated outputs follow their inputs.

`timescale 1ns/1ns

module configurable_registered_buffer
  import regbuf_pkg::*;
(
  // System clock domain
  input  wire logic                 clk_sys,
  input  wire logic                 sys_rst,
  // Link clock (differential pair)
  input  wire logic                 clk_link,
  input  wire logic                 clk_link_neg,
  input  wire logic                 reset_n,
  // Static configuration
  input  wire logic                 fanout_select_pin,
  input  wire logic                 bank_select_pin,
  // Command and address inputs, channel n at bit n-1
  input  wire logic [WIDE_BITS-1:0] data_in_bit,
  input  wire logic                 secondary_chip_select_in,
  // Registered outputs
  output logic      [WIDE_BITS-1:0] data_out_bit,
  output logic      [NARROW_BITS-1:0] copy_b_out,
  output logic                      clock_enable_out,
  output logic                      termination_ctrl_out,
  output logic                      chip_select_out,
  // Status seen on the system clock
  output logic      [1:0]           mode_status,
  output logic                      receivers_ready
);

  // Clear for link-side flops; either reset source acts without a clock
  logic link_clear;
  assign link_clear = !reset_n || sys_rst;

  // Configuration pins enter through two flops on the link clock
  logic [1:0] cfg_meta_reg;
  logic [1:0] cfg_sync_reg;
  always_ff @(posedge clk_link or posedge link_clear) begin
    if (link_clear) begin
      cfg_meta_reg <= SYNC_RESET;
      cfg_sync_reg <= SYNC_RESET;
    end else begin
      cfg_meta_reg <= {fanout_select_pin, bank_select_pin};
      cfg_sync_reg <= cfg_meta_reg;
    end
  end

  mode_t mode;
  assign mode = mode_t'(cfg_sync_reg);

  wire is_narrow = (mode == MODE_BANK_A) || (mode == MODE_BANK_B);
  wire is_bank_b = (mode == MODE_BANK_B);

  // Per-mode masks
  wire [WIDE_BITS-1:0] ungated_mask;
  wire [WIDE_BITS-1:0] active_mask;
  assign ungated_mask = is_bank_b ? UNGATED_BANK_B :
                        is_narrow ? UNGATED_BANK_A :
                        UNGATED_1TO1;
  assign active_mask  = is_narrow ? ACTIVE_NARROW : ACTIVE_WIDE;

  // Receivers off in reset; unused terminals held idle
  wire [WIDE_BITS-1:0] rx_data;
  assign rx_data = reset_n ? (data_in_bit & active_mask) : ALL_ZERO_WIDE;

  wire rx_cs_primary   = reset_n & data_in_bit[POS_CS];
  wire rx_cs_secondary = reset_n & secondary_chip_select_in;

  // Both chip selects high suspends the gated channels only
  wire suspend = rx_cs_primary && rx_cs_secondary;
  wire [WIDE_BITS-1:0] hold_mask;
  assign hold_mask = suspend ? ~ungated_mask : ALL_ZERO_WIDE;

  logic [WIDE_BITS-1:0] captured;
  capture_slice #(
    .W (WIDE_BITS)
  ) u_capture (
    .clk_link (clk_link),
    .clear    (link_clear),
    .d        (rx_data),
    .hold     (hold_mask),
    .q        (captured)
  );

  // Unused outputs forced low; copy B mirrors copy A in 1:2
  assign data_out_bit = captured & active_mask;
  assign copy_b_out   = is_narrow ? captured[NARROW_BITS-1:0] :
                        ALL_ZERO_WIDE[NARROW_BITS-1:0];

  // Named views of the always-live channels
  assign clock_enable_out     = is_bank_b ? captured[POS_B_CKE] : captured[POS_1TO1_CKE];
  assign termination_ctrl_out = is_bank_b ? captured[POS_B_ODT] : captured[POS_1TO1_ODT];
  assign chip_select_out      = captured[POS_CS];

  // Status into the system domain through two flops each
  logic [1:0] mode_meta_reg;
  logic [1:0] mode_sync_reg;
  logic       rdy_meta_reg;
  logic       rdy_sync_reg;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      mode_meta_reg <= SYNC_RESET;
      mode_sync_reg <= SYNC_RESET;
      rdy_meta_reg  <= 1'b0;
      rdy_sync_reg  <= 1'b0;
    end else begin
      mode_meta_reg <= {fanout_select_pin, bank_select_pin};
      mode_sync_reg <= mode_meta_reg;
      rdy_meta_reg  <= reset_n;
      rdy_sync_reg  <= rdy_meta_reg;
    end
  end

  assign mode_status     = mode_sync_reg;
  assign receivers_ready = rdy_sync_reg;

endmodule // configurable_registered_buffer

// *** ctrl_model.sv ***
// Controller-side model that launches command lines on the link clock.
// Assumes the bench hands it one word and one chip-select level at a time.
`timescale 1ns/1ns
module ctrl_model
  import regbuf_pkg::*;
(
  // Link clock and bench side
  input  wire logic                 clk_link,
  input  wire logic [WIDE_BITS-1:0] word,
  input  wire logic                 cs2,
  // Lines toward the buffer
  output logic      [WIDE_BITS-1:0] data_in_bit = '0,
  output logic                      secondary_chip_select_in = 1'b0
);
  always @(posedge clk_link) begin
    data_in_bit <= word;
    secondary_chip_select_in <= cs2;
  end
endmodule // ctrl_model

// *** regbuf_checker.sv ***
// Concurrent checks on the link side of the registered buffer.
// Assumes the configuration pins change only while reset is held.
`timescale 1ns/1ns
module regbuf_checker
  import regbuf_pkg::*;
(
  // Clock, resets and configuration
  input wire logic                   clk_link,
  input wire logic                   reset_n,
  input wire logic                   sys_rst,
  input wire logic                   fanout_select_pin,
  input wire logic                   bank_select_pin,
  // Link lines
  input wire logic [WIDE_BITS-1:0]   data_in_bit,
  input wire logic                   secondary_chip_select_in,
  input wire logic [WIDE_BITS-1:0]   data_out_bit,
  input wire logic [NARROW_BITS-1:0] copy_b_out,
  input wire logic                   clock_enable_out,
  input wire logic                   termination_ctrl_out,
  input wire logic                   chip_select_out
);
  logic [1:0]           settle_reg;
  logic [WIDE_BITS-1:0] din_reg;
  wire                  bank_b = fanout_select_pin & bank_select_pin;
  wire [WIDE_BITS-1:0]  ung = bank_b ? UNGATED_BANK_B : UNGATED_1TO1;
  wire [WIDE_BITS-1:0]  gat = ~ung & (fanout_select_pin ? ACTIVE_NARROW : ACTIVE_WIDE);
  wire [WIDE_BITS-1:0]  gq = data_out_bit & gat;
  wire                  ok = settle_reg == 2'h3;
  // Checks start once the synced mode has settled after reset
  always_ff @(posedge clk_link or negedge reset_n or posedge sys_rst)
    if (!reset_n || sys_rst) settle_reg <= 2'h0;
    else if (!ok) settle_reg <= settle_reg + 2'h1;
  always_ff @(posedge clk_link) din_reg <= data_in_bit;
  default clocking @(posedge clk_link); endclocking
  default disable iff (!reset_n || sys_rst);
  sequence s_suspend; ok && data_in_bit[POS_CS] && secondary_chip_select_in; endsequence
  property p_reset; disable iff (1'b0)
    !reset_n |-> {data_out_bit, copy_b_out, clock_enable_out, termination_ctrl_out, chip_select_out} == '0; endproperty
  a_reset: assert property (p_reset) else $error("outputs not low in reset");
  property p_hold; s_suspend |=> $stable(gq); endproperty
  a_hold: assert property (p_hold) else $error("gated bits moved");
  property p_follow; ok && !(data_in_bit[POS_CS] && secondary_chip_select_in) |=> gq == (din_reg & gat); endproperty
  a_follow: assert property (p_follow) else $error("gated bits stale");
  property p_ungated; ok |=> (data_out_bit & ung) == (din_reg & ung); endproperty
  a_ungated: assert property (p_ungated) else $error("ungated bits wrong");
  property p_cs; ok |=> chip_select_out == din_reg[POS_CS]; endproperty
  a_cs: assert property (p_cs) else $error("chip select out wrong");
  property p_fixed; ok |=> clock_enable_out == din_reg[bank_b ? POS_B_CKE : POS_1TO1_CKE]
    && termination_ctrl_out == din_reg[bank_b ? POS_B_ODT : POS_1TO1_ODT]; endproperty
  a_fixed: assert property (p_fixed) else $error("enable or termination wrong");
  property p_copy; ok |-> copy_b_out == (fanout_select_pin ? data_out_bit[NARROW_BITS-1:0] : '0); endproperty
  a_copy: assert property (p_copy) else $error("copy b wrong");
  property p_unused; ok && fanout_select_pin |-> data_out_bit[WIDE_BITS-1:NARROW_BITS] == '0; endproperty
  a_unused: assert property (p_unused) else $error("unused outputs high");
endmodule // regbuf_checker

bind configurable_registered_buffer regbuf_checker u_chk (.*);

// *** test_configurable_registered_buffer.sv ***
// Self-checking bench for the registered buffer in every mapping.
// Assumes the controller model launches each word one link edge after the bench.
`timescale 1ns/1ns
module test_configurable_registered_buffer
  import regbuf_pkg::*;
;
  // Resets start idle and are raised on the first clock edge, so the clear edge is never lost at time zero
  logic clk_sys = 1'b0, sys_rst = 1'b0, clk_link = 1'b0, reset_n = 1'b1, fan = 1'b0, bank = 1'b0, cs2 = 1'b0;
  logic [WIDE_BITS-1:0] word = '0, din, dout, exp_q;
  logic [NARROW_BITS-1:0] cpb;
  logic [1:0] mst;
  logic cke, odt, cso, sec, rdy;
  int mismatches = 0, n_compared = 0, cyc = 0;
  always #20 clk_sys = ~clk_sys;
  always #15 clk_link = ~clk_link;
  ctrl_model u_ctrl (.clk_link(clk_link), .word(word), .cs2(cs2), .data_in_bit(din), .secondary_chip_select_in(sec));
  configurable_registered_buffer u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_link(clk_link),
    .clk_link_neg(~clk_link), .reset_n(reset_n), .fanout_select_pin(fan), .bank_select_pin(bank),
    .data_in_bit(din), .secondary_chip_select_in(sec), .data_out_bit(dout), .copy_b_out(cpb),
    .clock_enable_out(cke), .termination_ctrl_out(odt), .chip_select_out(cso), .mode_status(mst),
    .receivers_ready(rdy));
  task automatic chk(input logic [WIDE_BITS-1:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk_sys) if (++cyc == 3000) begin
    mismatches++;
    conclude();
  end
  task automatic send(input logic [WIDE_BITS-1:0] w, input logic c);
    logic bb;
    logic [WIDE_BITS-1:0] u, g;
    bb = fan & bank;
    u = bb ? UNGATED_BANK_B : UNGATED_1TO1;
    g = ~u & (fan ? ACTIVE_NARROW : ACTIVE_WIDE);
    @(posedge clk_link);
    word <= w;
    cs2 <= c;
    repeat (2) @(posedge clk_link);
    #1;
    exp_q = ((w[POS_CS] & c) ? exp_q & g : w & g) | (w & u);
    chk(dout, exp_q);
    chk(cpb, fan ? exp_q[NARROW_BITS-1:0] : '0);
    chk({cke, odt, cso}, {w[bb ? POS_B_CKE : POS_1TO1_CKE], w[bb ? POS_B_ODT : POS_1TO1_ODT], w[POS_CS]});
    // The same word is still on the inputs; nothing may move before the next rising edge
    @(negedge clk_link);
    chk(dout, exp_q);
  endtask
  task automatic t_mode(input logic f, b);
    @(posedge clk_sys);
    reset_n <= 1'b0;
    sys_rst <= 1'b1;
    fan <= f;
    bank <= b;
    word <= '1;
    #1 chk(dout, '0);
    chk(cpb, '0);
    chk(rdy, 1'b0);
    repeat (2) @(posedge clk_sys);
    chk(dout, '0);
    reset_n <= 1'b1;
    sys_rst <= 1'b0;
    exp_q = '0;
    repeat (4) @(posedge clk_link);
    chk(mst, {f, b});
    chk(rdy, 1'b1);
    send(25'h15A5A5A, 1'b0);
    send(25'h0A5A5E5, 1'b1);
    send(25'h15A5A1A, 1'b1);
    send(25'h1FFFFFF, 1'b1);
  endtask
  initial begin
    t_mode(1'b0, 1'b0);
    t_mode(1'b1, 1'b0);
    t_mode(1'b1, 1'b1);
    t_mode(1'b0, 1'b1);
    conclude();
  end
endmodule // test_configurable_registered_buffer
